/* core/phy_mii_link_control.sv */
// MAC-facing control: EEE gating, isolate, resets, carrier, collision, link monitor
`timescale 1ns/1ps
module phy_mii_link_control #(
  parameter int unsigned LINK_WAIT = phy_link_pkg::LINK_WAIT_CYC
) (
  // Clocks and reset
  input wire logic ref_clk_i,
  input wire logic link_clk_i,
  input wire logic rst_b_i,
  // Straps and line status pins
  input wire logic reduced_interface_select_strap_i,
  input wire logic interrupt_pin_select_strap_i,
  input wire logic line_signal_valid_i,
  input wire logic link_10_status_i,
  // Configuration
  input wire logic cfg_we_i,
  input wire logic cfg_isolate_i,
  input wire logic cfg_coll_test_i,
  input wire logic cfg_an_enable_i,
  input wire logic cfg_eee_adv_i,
  input wire logic cfg_eee_adv_we_i,
  input wire logic phy_eee_enable_we_i,
  input wire logic phy_eee_enable_i,
  input wire logic soft_reset_i,
  // Operating mode from negotiation
  input wire logic an_link_enable_i,
  input wire logic speed_100_i,
  input wire logic full_duplex_i,
  input wire logic repeater_mode_i,
  // Status
  output logic soft_reset_o,
  output logic isolate_o,
  output logic coll_test_o,
  output logic an_enable_o,
  output logic phy_eee_enable_o,
  output logic eee_cap_100_o,
  output logic eee_adv_100_o,
  output logic lpi_allowed_o,
  output logic link_status_o,
  output logic link_indicator_output_o,
  output logic link_active_o,
  output logic mac_if_clk_o,
  output logic mac_if_fast_o,
  // Link side
  input wire logic rx_code_bit_i,
  input wire logic tx_en_i,
  input wire logic tx_er_i,
  input wire logic [3:0] txd_i,
  output logic tx_en_o,
  output logic tx_er_o,
  output logic [3:0] txd_o,
  output logic crs_o,
  output logic crs_dv_o,
  output logic col_o
);

  // ****************************************
  // Reference clock domain state
  // ****************************************
  localparam int unsigned CNT_W_L = phy_link_pkg::CNT_W;
  localparam logic [phy_link_pkg::WAIT_W-1:0] LINK_WAIT_L = phy_link_pkg::WAIT_W'(LINK_WAIT);
  typedef phy_link_pkg::link_mon_e link_mon_l;
  typedef struct packed {
    logic [2:0] valid_sync;
    logic [2:0] l10_sync;
    logic [2:0] rmii_sync;
    logic [2:0] intsel_sync;
    logic [1:0] boot;
    logic rmii;
    logic intsel;
    logic isolate;
    logic coll_test;
    logic an_enable;
    logic eee_enable;
    logic eee_adv;
    logic sr_busy;
    logic [CNT_W_L-1:0] sr_cnt;
    logic [CNT_W_L-1:0] slow_cnt;
    logic fast;
    logic [4:0] div_cnt;
    logic mac_clk;
    link_mon_l mon;
    logic [phy_link_pkg::WAIT_W-1:0] wait_cnt;
    logic link_status;
  } ref_s;

  ref_s r_q;
  ref_s r_d;
  logic valid_s;
  logic l10_s;
  logic [4:0] half_per;

  // Valid needs both of the last two stages high; either one low clears it
  assign valid_s = r_q.valid_sync[2] & r_q.valid_sync[1];
  assign l10_s = r_q.l10_sync[2] & r_q.l10_sync[1];
  assign half_per = r_q.fast ? 5'(phy_link_pkg::MAC_FAST_HALF)
                             : 5'(phy_link_pkg::MAC_SLOW_HALF);

  always_comb
  begin
    r_d = r_q;
    r_d.valid_sync = {r_q.valid_sync[1:0], line_signal_valid_i};
    r_d.l10_sync = {r_q.l10_sync[1:0], link_10_status_i};
    r_d.rmii_sync = {r_q.rmii_sync[1:0], reduced_interface_select_strap_i};
    r_d.intsel_sync = {r_q.intsel_sync[1:0], interrupt_pin_select_strap_i};
    // Straps caught on the third cycle, before the strap reaches the last synchroniser stage
    if (r_q.boot != 2'h3)
    begin
      r_d.boot = r_q.boot + 2'h1;
      if (r_q.boot == 2'h2)
      begin
        r_d.rmii = r_q.rmii_sync[2];
        r_d.intsel = r_q.intsel_sync[2];
      end
    end
    // Configuration writes are refused while soft reset runs
    if (!r_q.sr_busy)
    begin
      if (cfg_we_i)
      begin
        r_d.isolate = cfg_isolate_i;
        r_d.coll_test = cfg_coll_test_i;
        r_d.an_enable = cfg_an_enable_i;
      end
      if (phy_eee_enable_we_i)
        r_d.eee_enable = phy_eee_enable_i;
      if (cfg_eee_adv_we_i)
        r_d.eee_adv = cfg_eee_adv_i;
      if (soft_reset_i)
      begin
        // Sticky EEE enable is kept; advert default follows it
        r_d.sr_busy = 1'b1;
        r_d.sr_cnt = '0;
        r_d.isolate = phy_link_pkg::RST_ISOLATE;
        r_d.coll_test = 1'b0;
        r_d.an_enable = phy_link_pkg::RST_AN_ENABLE;
        r_d.eee_adv = r_q.eee_enable;
        r_d.slow_cnt = '0;
        r_d.fast = 1'b0;
      end
    end
    else if (r_q.sr_cnt == CNT_W_L'(phy_link_pkg::SOFT_RESET_CYC - 1))
      r_d.sr_busy = 1'b0;
    else
      r_d.sr_cnt = r_q.sr_cnt + 1'b1;
    // Slow interface clock after any reset
    if (!r_q.fast && !r_q.sr_busy && !(soft_reset_i && !r_q.sr_busy))
    begin
      if (r_q.slow_cnt == CNT_W_L'(phy_link_pkg::SLOW_IF_CYC - 1))
        r_d.fast = r_q.an_enable;
      else
        r_d.slow_cnt = r_q.slow_cnt + 1'b1;
    end
    if (r_q.div_cnt >= half_per - 5'h1)
    begin
      r_d.div_cnt = '0;
      r_d.mac_clk = ~r_q.mac_clk;
    end
    else
      r_d.div_cnt = r_q.div_cnt + 5'h1;
    // Link monitor
    case (r_q.mon)
      phy_link_pkg::LM_DOWN:
        if (valid_s)
        begin
          r_d.wait_cnt = '0;
          r_d.mon = r_q.an_enable ? phy_link_pkg::LM_WAIT : phy_link_pkg::LM_UP;
        end
      phy_link_pkg::LM_WAIT:
        if (r_q.wait_cnt == LINK_WAIT_L - 1'b1)
          r_d.mon = phy_link_pkg::LM_READY;
        else
          r_d.wait_cnt = r_q.wait_cnt + 1'b1;
      phy_link_pkg::LM_READY:
        if (an_link_enable_i || !r_q.an_enable)
          r_d.mon = phy_link_pkg::LM_UP;
      phy_link_pkg::LM_UP:
        r_d.mon = phy_link_pkg::LM_UP;
      default:
        r_d.mon = phy_link_pkg::LM_DOWN;
    endcase
    if (!valid_s)
      r_d.mon = phy_link_pkg::LM_DOWN;
    // 10BASE-T takes its own receiver result
    r_d.link_status = speed_100_i ? (r_d.mon == phy_link_pkg::LM_UP) : l10_s;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r_q <= '0;
      r_q.an_enable <= phy_link_pkg::RST_AN_ENABLE;
      r_q.eee_enable <= phy_link_pkg::RST_EEE_ENABLE;
      r_q.eee_adv <= phy_link_pkg::RST_EEE_ENABLE;
      r_q.mon <= phy_link_pkg::LM_DOWN;
    end
    else
      r_q <= r_d;
  end

  assign soft_reset_o = r_q.sr_busy;
  assign isolate_o = r_q.isolate;
  assign coll_test_o = r_q.coll_test;
  assign an_enable_o = r_q.an_enable;
  assign phy_eee_enable_o = r_q.eee_enable;
  assign eee_cap_100_o = r_q.eee_enable;
  assign eee_adv_100_o = r_q.eee_adv;
  assign link_status_o = r_q.link_status;
  assign link_indicator_output_o = r_q.link_status;
  assign link_active_o = (r_q.mon == phy_link_pkg::LM_UP);
  assign mac_if_clk_o = r_q.mac_clk;
  assign mac_if_fast_o = r_q.fast;
  // Low-power idle only when advertised, at 100 full duplex; the MII and strap terms read the boot capture, which is always low
  assign lpi_allowed_o = r_q.eee_enable & ~r_q.rmii & ~r_q.intsel & r_q.eee_adv
                       & r_q.link_status & speed_100_i & full_duplex_i;

  // ****************************************
  // Link clock domain state
  // ****************************************
  typedef struct packed {
    logic [5:0] m1;
    logic [5:0] m2;
    logic [9:0] win;
    logic [2:0] bit_cnt;
    phy_link_pkg::carrier_e cs;
    logic tx_en;
    logic tx_er;
    logic [3:0] txd;
    logic crs;
    logic col;
  } lnk_s;

  lnk_s l_q;
  lnk_s l_d;
  logic [9:0] win_n;
  logic rx_car;
  logic iso_l;
  logic coll_l;
  logic up_l;
  logic fdx_l;
  logic rep_l;
  logic rmii_l;

  // Quasi-static levels from the reference domain, two flops each
  assign {iso_l, coll_l, up_l, fdx_l, rep_l, rmii_l} = l_q.m2;
  assign win_n = {l_q.win[8:0], rx_code_bit_i};

  function automatic logic two_zeros(input logic [9:0] w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++)
      for (int j = i + 2; j < 10; j++)
        hit = hit | (~w[i] & ~w[j]);
    return hit;
  endfunction

  always_comb
  begin
    l_d = l_q;
    l_d.m1 = {r_q.isolate, r_q.coll_test, link_active_o, full_duplex_i, repeater_mode_i,
              r_q.rmii};
    l_d.m2 = l_q.m1;
    l_d.win = win_n;
    l_d.bit_cnt = (l_q.bit_cnt == phy_link_pkg::SYM_LAST) ? 3'h0 : l_q.bit_cnt + 3'h1;
    case (l_q.cs)
      phy_link_pkg::CS_IDLE:
        if (two_zeros(win_n))
          l_d.cs = phy_link_pkg::CS_PRE;
      phy_link_pkg::CS_PRE:
        if (win_n == phy_link_pkg::CODE_SSD)
        begin
          l_d.cs = phy_link_pkg::CS_STREAM;
          l_d.bit_cnt = 3'h0;
        end
        else if (win_n == phy_link_pkg::CODE_ONES)
          l_d.cs = phy_link_pkg::CS_IDLE;
      phy_link_pkg::CS_STREAM:
        if (l_q.bit_cnt == phy_link_pkg::SYM_LAST)
        begin
          if (win_n[4:0] == phy_link_pkg::CODE_T)
            l_d.cs = phy_link_pkg::CS_AFTER_T;
          else if (win_n[4:0] == phy_link_pkg::CODE_IDLE)
            l_d.cs = phy_link_pkg::CS_AFTER_I;
        end
      phy_link_pkg::CS_AFTER_T:
        if (l_q.bit_cnt == phy_link_pkg::SYM_LAST)
          l_d.cs = (win_n[4:0] == phy_link_pkg::CODE_R) ? phy_link_pkg::CS_IDLE
                                                       : phy_link_pkg::CS_STREAM;
      phy_link_pkg::CS_AFTER_I:
        if (l_q.bit_cnt == phy_link_pkg::SYM_LAST)
          l_d.cs = (win_n[4:0] == phy_link_pkg::CODE_IDLE) ? phy_link_pkg::CS_IDLE
                                                          : phy_link_pkg::CS_STREAM;
      default:
        l_d.cs = phy_link_pkg::CS_IDLE;
    endcase
    // Receive and transmit stay quiet until the link is up
    if (!up_l)
      l_d.cs = phy_link_pkg::CS_IDLE;
    rx_car = (l_d.cs == phy_link_pkg::CS_PRE) || (l_d.cs == phy_link_pkg::CS_STREAM);
    l_d.tx_en = tx_en_i & ~iso_l & up_l;
    l_d.tx_er = tx_er_i & ~iso_l & up_l;
    l_d.txd = (iso_l || !up_l) ? 4'h0 : txd_i;
    l_d.crs = rx_car | (l_d.tx_en & ~fdx_l & ~rep_l);
    // In half duplex, test mode echoes transmit enable within one link clock
    l_d.col = ~fdx_l & ((l_d.tx_en & rx_car) | (coll_l & l_d.tx_en));
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      l_q <= '0;
      l_q.win <= phy_link_pkg::CODE_ONES;
      l_q.cs <= phy_link_pkg::CS_IDLE;
    end
    else
      l_q <= l_d;
  end

  assign tx_en_o = l_q.tx_en;
  assign tx_er_o = l_q.tx_er;
  assign txd_o = l_q.txd;
  assign crs_o = l_q.crs & ~rmii_l;
  assign crs_dv_o = l_q.crs & rmii_l;
  assign col_o = l_q.col;

endmodule

/* include/phy_link_pkg.sv */
// Constants and types for the MAC-facing link control block
package phy_link_pkg;

  // ****************************************
  // Clocking and timing
  // ****************************************
  localparam int unsigned REF_CLK_KHZ = 100000;
  localparam int unsigned SLOW_IF_US = 16;
  localparam int unsigned SLOW_IF_CYC = SLOW_IF_US * REF_CLK_KHZ / 1000;
  localparam int unsigned LINK_WAIT_MS = 330;
  localparam int unsigned LINK_WAIT_CYC = LINK_WAIT_MS * REF_CLK_KHZ;
  localparam int unsigned SOFT_RESET_NS = 1000;
  localparam int unsigned SOFT_RESET_CYC = SOFT_RESET_NS * REF_CLK_KHZ / 1000000;
  localparam int unsigned MAC_SLOW_KHZ = 2500;
  localparam int unsigned MAC_FAST_KHZ = 25000;
  localparam int unsigned MAC_SLOW_HALF = REF_CLK_KHZ / (2 * MAC_SLOW_KHZ);
  localparam int unsigned MAC_FAST_HALF = REF_CLK_KHZ / (2 * MAC_FAST_KHZ);
  localparam int unsigned WAIT_W = 26;
  localparam int unsigned CNT_W = 11;

  // ****************************************
  // Reset values and code groups
  // ****************************************
  localparam logic RST_ISOLATE = 1'b0;
  localparam logic RST_EEE_ENABLE = 1'b0;
  localparam logic RST_AN_ENABLE = 1'b1;
  localparam logic [9:0] CODE_SSD = 10'h311;
  localparam logic [9:0] CODE_ONES = 10'h3FF;
  localparam logic [4:0] CODE_T = 5'h0D;
  localparam logic [4:0] CODE_R = 5'h07;
  localparam logic [4:0] CODE_IDLE = 5'h1F;
  localparam logic [2:0] SYM_LAST = 3'h4;

  typedef enum logic [1:0] {
    LM_DOWN = 2'b00,
    LM_WAIT = 2'b01,
    LM_READY = 2'b10,
    LM_UP = 2'b11
  } link_mon_e;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_PRE = 3'b001,
    CS_STREAM = 3'b010,
    CS_AFTER_T = 3'b011,
    CS_AFTER_I = 3'b100
  } carrier_e;

endpackage

/* verification/mac_model.sv */
// Behavioural MAC transmit side on the link clock
`timescale 1ns/1ps
module mac_model (
  // Link clock and reset
  input wire logic link_clk_i,
  input wire logic rst_b_i,
  // Frame request, toggle starts a frame
  input wire logic req_i,
  input wire logic [7:0] len_i,
  // Transmit pins
  output logic tx_en_o,
  output logic tx_er_o,
  output logic [3:0] txd_o
);
  logic req_q;
  logic [7:0] left_q;
  always @(negedge link_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      req_q <= 1'h0;
      left_q <= 8'h00;
      tx_en_o <= 1'h0;
      tx_er_o <= 1'h0;
      txd_o <= 4'h0;
    end
    else
    begin
      req_q <= req_i;
      left_q <= (req_q != req_i) ? len_i : (left_q != 8'h00) ? left_q - 8'h01 : 8'h00;
      tx_en_o <= left_q != 8'h00;
      // Every frame carries an error mark so the isolate gate is seen on it
      tx_er_o <= left_q != 8'h00;
      // Idle data keeps moving so a missing gate cannot pass by luck
      txd_o <= (left_q != 8'h00) ? 4'($urandom) : ~txd_o;
    end
endmodule

/* verification/phy_link_chk.sv */
// Concurrent checks on the link control block ports
`timescale 1ns/1ps
module phy_link_chk (
  // Clocks and reset
  input wire logic ref_clk_i,
  input wire logic link_clk_i,
  input wire logic rst_b_i,
  // Watched inputs
  input wire logic line_signal_valid_i,
  input wire logic speed_100_i,
  input wire logic full_duplex_i,
  input wire logic tx_en_i,
  // Watched outputs
  input wire logic soft_reset_o,
  input wire logic isolate_o,
  input wire logic coll_test_o,
  input wire logic an_enable_o,
  input wire logic phy_eee_enable_o,
  input wire logic eee_adv_100_o,
  input wire logic lpi_allowed_o,
  input wire logic link_status_o,
  input wire logic link_indicator_output_o,
  input wire logic link_active_o,
  input wire logic tx_en_o,
  input wire logic crs_o,
  input wire logic col_o,
  input wire logic mac_if_clk_o,
  input wire logic mac_if_fast_o
);
  mclk_fast_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mac_if_fast_o && $past(mac_if_fast_o, 3) |-> mac_if_clk_o != $past(mac_if_clk_o, 2))
    else $error("fast clock rate");
  mclk_slow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $past(rst_b_i, 21) && !mac_if_fast_o && !$past(mac_if_fast_o, 21)
    |-> mac_if_clk_o != $past(mac_if_clk_o, 20)) else $error("slow clock rate");
  sr_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(soft_reset_o) |-> ##99 soft_reset_o ##1 !soft_reset_o) else $error("soft len");
  sr_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    soft_reset_o |=> $stable(phy_eee_enable_o)) else $error("sticky lost");
  sr_clr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $fell(soft_reset_o) |-> !isolate_o && !coll_test_o && an_enable_o
    && eee_adv_100_o == phy_eee_enable_o) else $error("soft defaults");
  lpi_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    lpi_allowed_o |-> phy_eee_enable_o && eee_adv_100_o && speed_100_i
    && full_duplex_i) else $error("lpi gate");
  led_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    link_indicator_output_o == link_status_o) else $error("led mismatch");
  drop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $fell(line_signal_valid_i) |-> ##[1:6] !link_active_o) else $error("link drop");
  iso_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    isolate_o && $past(isolate_o, 4) |-> !tx_en_o) else $error("isolate leak");
  fd_col_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    full_duplex_i && $past(full_duplex_i, 4) |-> !col_o) else $error("col in fd");
  ct_a: assert property (@(posedge link_clk_i) disable iff (!rst_b_i)
    $rose(tx_en_i) && coll_test_o && !full_duplex_i |-> ##[1:4] col_o)
    else $error("col test");
  cover property (@(posedge ref_clk_i) $rose(link_active_o));
  cover property (@(posedge link_clk_i) $rose(col_o));
  cover property (@(posedge link_clk_i) $rose(crs_o));
endmodule

/* verification/tb.sv */
// Self-checking bench for the link control block
`timescale 1ns/1ps
module tb;
  logic ref_clk_i = 1'h0, link_clk_i = 1'h0, rst_b_i = 1'h0, req = 1'h0;
  logic cfg_we_i = 1'h0, cfg_isolate_i = 1'h0, cfg_coll_test_i = 1'h0, cfg_an_enable_i = 1'h1;
  logic cfg_eee_adv_i = 1'h0, cfg_eee_adv_we_i = 1'h0, phy_eee_enable_we_i = 1'h0;
  logic phy_eee_enable_i = 1'h0, soft_reset_i = 1'h0, an_link_enable_i = 1'h0;
  logic speed_100_i = 1'h1, full_duplex_i = 1'h1, line_signal_valid_i = 1'h0;
  logic link_10_status_i = 1'h0, rx_code_bit_i = 1'h1, tx_en_i, tx_er_i;
  logic [3:0] txd_i, txd_o;
  logic [7:0] len = 8'h14;
  logic soft_reset_o, isolate_o, coll_test_o, an_enable_o, phy_eee_enable_o, eee_cap_100_o;
  logic eee_adv_100_o, lpi_allowed_o, link_status_o, link_indicator_output_o, link_active_o;
  logic mac_if_clk_o, mac_if_fast_o, tx_en_o, tx_er_o, crs_o, crs_dv_o, col_o;
  logic [15:0] obs;
  logic e_q[$];
  int s_q[$];
  int err_total = 0, checked = 0;
  string nm [16] = '{"iso", "an", "eee", "adv", "lpi", "srst", "fast", "act", "link", "crs",
    "col", "txen", "cap", "crsdv", "txd", "txer"};
  logic [9:0] ch [13] = '{10'h3FF, 10'h3F5, 10'h3FF, 10'h3FF, 10'h311, 10'h2D5, 10'h1B6,
    10'h1A7, 10'h3FF, 10'h311, 10'h3F6, 10'h3FF, 10'h3FF};
  // Tail of an ended stream still holds two spaced zeros, so carrier returns briefly
  logic [12:0] ce = 13'h0DE4;
  assign obs = {tx_er_o, |txd_o, crs_dv_o, eee_cap_100_o, tx_en_o, col_o, crs_o, link_status_o,
    link_active_o, mac_if_fast_o,
    soft_reset_o, lpi_allowed_o, eee_adv_100_o, phy_eee_enable_o, an_enable_o, isolate_o};
  phy_mii_link_control #(.LINK_WAIT(50)) phy_mii_link_control_i (
    .reduced_interface_select_strap_i(1'h0),
    .interrupt_pin_select_strap_i(1'h0),
    .repeater_mode_i(1'h0),
    .*
  );
  mac_model mac_model_i (.link_clk_i, .rst_b_i, .req_i(req), .len_i(len), .tx_en_o(tx_en_i),
    .tx_er_o(tx_er_i), .txd_o(txd_i));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  initial
  begin
    #3.3;
    forever #6 link_clk_i = ~link_clk_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic chk(input int s, input logic e);
    s_q.push_back(s);
    e_q.push_back(e);
  endtask
  task automatic cfg(input logic iso, input logic ct, input logic an);
    cfg_isolate_i = iso;
    cfg_coll_test_i = ct;
    cfg_an_enable_i = an;
    cfg_we_i = 1'h1;
    cyc(1);
    cfg_we_i = 1'h0;
  endtask
  task automatic eee(input logic en, input logic adv);
    phy_eee_enable_i = en;
    cfg_eee_adv_i = adv;
    phy_eee_enable_we_i = 1'h1;
    cfg_eee_adv_we_i = 1'h1;
    cyc(1);
    phy_eee_enable_we_i = 1'h0;
    cfg_eee_adv_we_i = 1'h0;
  endtask
  task automatic rxb(input logic [9:0] c, input logic e);
    for (int i = 9; i >= 0; i--)
    begin
      @(negedge link_clk_i);
      rx_code_bit_i = c[i];
      if (i == 7)
        chk(9, e);
    end
  endtask
  task automatic frame(input int s, input logic e, input logic t);
    cyc(3);
    len = 8'($urandom_range(40, 20));
    req = ~req;
    cyc(10);
    chk(s, e);
    chk(15, t);
    chk(13, 1'h0);
    if (!t)
      chk(14, 1'h0);
    cyc(50);
    chk(s, 1'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Results are compared once settled, 2 ns after each falling edge
  initial forever
  begin
    int s;
    logic e;
    @(negedge ref_clk_i);
    #2;
    while (s_q.size() > 0)
    begin
      s = s_q.pop_front();
      e = e_q.pop_front();
      checked++;
      if (obs[s] !== e)
      begin
        err_total++;
        $display("BAD %s expected %b seen %b", nm[s], e, obs[s]);
      end
    end
  end
  initial
  begin
    #60000;
    err_total++;
    conclude();
  end
  initial
  begin
    void'($urandom(54466));
    cyc(4);
    rst_b_i = 1'h1;
    cyc(1);
    chk(0, 1'h0);
    chk(2, 1'h0);
    chk(3, 1'h0);
    chk(12, 1'h0);
    eee(1'h1, 1'h0);
    chk(2, 1'h1);
    chk(12, 1'h1);
    chk(4, 1'h0);
    eee(1'h1, 1'h1);
    chk(4, 1'h0);
    full_duplex_i = 1'h0;
    cyc(1);
    chk(4, 1'h0);
    eee(1'h1, 1'h0);
    cfg(1'h1, 1'h1, 1'h0);
    soft_reset_i = 1'h1;
    cyc(1);
    soft_reset_i = 1'h0;
    cyc(1);
    chk(5, 1'h1);
    cyc(20);
    cfg(1'h1, 1'h0, 1'h1);
    cyc(80);
    for (int i = 0; i < 4; i++)
      chk(i, i != 0);
    chk(5, 1'h0);
    chk(6, 1'h0);
    cyc(1450);
    chk(6, 1'h0);
    cyc(250);
    chk(6, 1'h1);
    full_duplex_i = 1'h1;
    line_signal_valid_i = 1'h1;
    cyc(70);
    chk(7, 1'h0);
    an_link_enable_i = 1'h1;
    cyc(6);
    chk(7, 1'h1);
    chk(8, 1'h1);
    chk(4, 1'h1);
    for (int i = 0; i < 13; i++)
      rxb(ch[i], ce[i]);
    frame(11, 1'h1, 1'h1);
    frame(9, 1'h0, 1'h1);
    full_duplex_i = 1'h0;
    frame(9, 1'h1, 1'h1);
    cfg(1'h0, 1'h1, 1'h1);
    frame(10, 1'h1, 1'h1);
    cfg(1'h1, 1'h0, 1'h1);
    frame(11, 1'h0, 1'h0);
    line_signal_valid_i = 1'h0;
    cyc(8);
    chk(7, 1'h0);
    chk(8, 1'h0);
    line_signal_valid_i = 1'h1;
    cyc(40);
    chk(7, 1'h0);
    cyc(20);
    chk(7, 1'h1);
    cfg(1'h0, 1'h0, 1'h0);
    line_signal_valid_i = 1'h0;
    cyc(8);
    line_signal_valid_i = 1'h1;
    cyc(8);
    chk(7, 1'h1);
    speed_100_i = 1'h0;
    line_signal_valid_i = 1'h0;
    link_10_status_i = 1'h1;
    cyc(8);
    chk(8, 1'h1);
    link_10_status_i = 1'h0;
    cyc(8);
    chk(8, 1'h0);
    cyc(2);
    conclude();
  end
endmodule
bind phy_mii_link_control phy_link_chk chk_i (.*);
